/* File: bench/smb_host.sv */
// Purpose: behavioural SMBus host driving the target's link pins
// Assumes: sda_line is the resolved wire level with pull-up
// Notes: every pin change lands on a link_clk rising edge
`timescale 1ns/1ps
`default_nettype none

module smb_host (
  input wire logic link_clk,
  input wire logic sda_line,
  output var logic scl_line,
  output var logic sda_low
);
  initial
  begin
    scl_line = 1'b1;
    sda_low = 1'b0;
  end

  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  // one phase is 300 ns so each scl level outlasts the sync handshake
  task automatic ph;
    repeat (20) @(posedge link_clk);
  endtask : ph

  task automatic pulse(output logic smp);
    ph();
    scl_line <= 1'b1;
    ph();
    @(negedge link_clk);
    smp = sda_line;
    @(posedge link_clk);
    scl_line <= 1'b0;
  endtask : pulse

  // start and repeated start share one shape
  task automatic start;
    ph();
    sda_low <= 1'b0;
    ph();
    scl_line <= 1'b1;
    ph();
    sda_low <= 1'b1;
    ph();
    scl_line <= 1'b0;
  endtask : start

  task automatic stop;
    ph();
    sda_low <= 1'b1;
    ph();
    scl_line <= 1'b1;
    ph();
    sda_low <= 1'b0;
  endtask : stop

  // ack returns the sampled ninth bit: 0 means acknowledged
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      ph();
      sda_low <= ~b[i];
      pulse(ack);
    end
    ph();
    sda_low <= 1'b0;
    pulse(ack);
  endtask : wbyte

  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic s;
    ph();
    sda_low <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(b[i]);
    end
    ph();
    sda_low <= ~nack;
    pulse(s);
    ph();
    sda_low <= 1'b0;
  endtask : rbyte
endmodule : smb_host

`default_nettype wire

/* File: bench/smbus_index_block_access_tb.sv */
// Purpose: self-checking bench of the indexed block access target
// Assumes: smb_host model drives scl and the host side of sda
// Notes: strap pin held high, identity parameters at their defaults
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    check_count = check_count + 1; \
    if ((got) !== (exp)) \
    begin \
      errors = errors + 1; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module smbus_index_block_access_tb;
  import smb_pkg::*;
  logic sys_clk;
  logic link_clk;
  logic rst;
  logic freq_strap;
  logic sda_out;
  logic sda_oe;
  logic scl_line;
  logic sda_low;
  wire logic sda_wire;
  cfg_array_t cfg_bytes;
  int errors = 0;
  int check_count = 0;

  assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));

  smb_host host (
    .link_clk(link_clk),
    .sda_line(sda_wire),
    .scl_line(scl_line),
    .sda_low(sda_low)
  );

  smbus_index_block_access #(
    .VENDOR_REV_ID(8'h5A),
    .DEVICE_ID(8'hA5)
  ) dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .link_clk(link_clk),
    .scl_in(scl_line),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .freq_strap(freq_strap),
    .cfg_bytes(cfg_bytes)
  );

  // ----------------------------------------
  // clocks and watchdog
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  initial
  begin
    #1000000;
    errors = errors + 1;
    complete_run();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic complete_run;
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // three data bytes from index idx, sent first byte in d[23:16]
  task automatic wr_xfer(input logic [7:0] idx, input logic [23:0] d);
    logic a;
    host.start();
    host.wbyte(8'hD2, a);
    `CHK(a, 1'b0)
    host.wbyte(idx, a);
    `CHK(a, 1'b0)
    host.wbyte(8'h03, a);
    `CHK(a, 1'b0)
    for (int i = 2; i >= 0; i--)
    begin
      host.wbyte(d[i*8 +: 8], a);
      `CHK(a, 1'b0)
    end
    host.stop();
    repeat (20) @(posedge sys_clk);
  endtask : wr_xfer

  task automatic t_reset;
    `CHK(cfg_bytes, 80'hA50A5A180F00003F9EFF)
  endtask : t_reset

  task automatic t_write;
    wr_xfer(8'h00, 24'hAA55C3);
    `CHK(cfg_bytes[0], 8'hAA)
    `CHK(cfg_bytes[1], 8'h15)
    `CHK(cfg_bytes[2], 8'h03)
    `CHK(cfg_bytes[3], 8'h00)
  endtask : t_write

  task automatic t_readonly;
    wr_xfer(8'h06, 24'hFF0003);
    `CHK(cfg_bytes[6], 8'hDF)
    `CHK(cfg_bytes[7], 8'h5A)
    `CHK(cfg_bytes[8], 8'h03)
  endtask : t_readonly

  task automatic t_read;
    logic a;
    logic [7:0] b;
    logic [23:0] exp_data;
    exp_data = 24'hAA1503;
    host.start();
    host.wbyte(8'hD2, a);
    host.wbyte(8'h00, a);
    `CHK(a, 1'b0)
    host.start();
    host.wbyte(8'hD3, a);
    `CHK(a, 1'b0)
    host.rbyte(1'b0, b);
    `CHK(b, 8'h03)
    for (int i = 2; i >= 0; i--)
    begin
      host.rbyte(i == 0, b);
      `CHK(b, exp_data[i*8 +: 8])
    end
    `CHK(sda_oe, 1'b0)
    host.stop();
  endtask : t_read

  task automatic t_badaddr;
    logic a;
    host.start();
    host.wbyte(8'hD4, a);
    `CHK(a, 1'b1)
    host.wbyte(8'h00, a);
    `CHK(a, 1'b1)
    host.stop();
    repeat (20) @(posedge sys_clk);
    `CHK(cfg_bytes[0], 8'hAA)
  endtask : t_badaddr

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    freq_strap = 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge link_clk);
    t_reset();
    t_write();
    t_readonly();
    t_read();
    t_badaddr();
    complete_run();
  end
endmodule : smbus_index_block_access_tb

`default_nettype wire

/* File: rtl/smb_params.svh */
// Purpose: constants of the indexed block access SMBus target
// Assumes: byte-wide configuration space of ten bytes
// Notes: included by the package and by the top module
//
// Function
// - write transfers are answered only for address byte D2 hex
// - read transfers are answered for address byte D3 hex
// - device acknowledges its write address and the starting index byte
// - host sends byte count after index; device acknowledges it
// - data bytes are stored at index N up to N+X-1 ascending
// - device acknowledges each of the X counted data bytes on its own; later data bytes are not acknowledged
// - device acknowledges read address before driving any data
// - first byte of a read is the count of data bytes
// - then consecutive bytes from the index; count held in byte 8
// - byte 8 holds a writable read-back count, reset to 0A hex
`ifndef SMB_PARAMS_SVH
`define SMB_PARAMS_SVH

`define SMB_WR_ADDR 8'hD2
`define SMB_RD_ADDR 8'hD3
`define CFG_BYTES 10
`define CFG_LAST_IDX 8'h09
`define CNT_IDX 8'h08
`define COUNT_RESET 8'h0A
`define STRAP_BYTE 6
`define STRAP_BIT 4
`define BIT_LAST 4'h7
`define BIT_DONE 4'h8
// bytes 9 down to 0; bytes 7 and 9 are replaced by identity parameters
`define CFG_RESET 80'h000A00080F00003F9EFF
`define CFG_WMASK 80'h00FF00CF1F00003F9FFF

`endif

/* File: rtl/smb_pkg.sv */
// Purpose: shared types of the indexed block access SMBus target
// Assumes: smb_params.svh gives the sizes
// Notes: none
`include "smb_params.svh"

package smb_pkg;

  typedef logic [`CFG_BYTES-1:0][7:0] cfg_array_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_HOLD,
    ST_ACK,
    ST_TX,
    ST_HACK,
    ST_WAIT
  } link_state_t;

  typedef enum logic [1:0] {
    K_ADDR,
    K_INDEX,
    K_COUNT,
    K_DATA
  } byte_kind_t;

endpackage : smb_pkg

/* File: rtl/smb_sync.sv */
// Purpose: two flip-flop synchroniser for levels
// Assumes: d is a level from another clock domain or a pin
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none

module smb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : smb_sync

`default_nettype wire

/* File: rtl/smbus_index_block_access.sv */
// Purpose: SMBus target giving indexed block access to configuration bytes
// Assumes: link_clk oversamples scl and sda; scl phases last well over 200 ns
// Notes: configuration bytes live on sys_clk; the bus engine on link_clk
`timescale 1ns/1ps
`default_nettype none
`include "smb_params.svh"

module smbus_index_block_access #(
  parameter logic [7:0] VENDOR_REV_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'hA5 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic freq_strap,
  output smb_pkg::cfg_array_t cfg_bytes
);

  import smb_pkg::*;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  logic link_rst;
  logic scl_s;
  logic sda_s;
  logic strap_s;
  logic req_sync;
  logic ack_sync;
  logic req_tgl_reg;
  logic ack_tgl_reg;

  smb_sync #(.W(1), .INIT(1'b1)) u_rst_sync (
    .clk(link_clk), .rst(1'b0), .d(rst), .q(link_rst)
  );
  smb_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
    .clk(link_clk), .rst(link_rst), .d({scl_in, sda_in}), .q({scl_s, sda_s})
  );
  smb_sync #(.W(1), .INIT(1'b0)) u_ack_sync (
    .clk(link_clk), .rst(link_rst), .d(ack_tgl_reg), .q(ack_sync)
  );
  smb_sync #(.W(1), .INIT(1'b0)) u_req_sync (
    .clk(sys_clk), .rst(rst), .d(req_tgl_reg), .q(req_sync)
  );
  // strap stage runs through reset so the pin level is settled at release
  smb_sync #(.W(1), .INIT(1'b0)) u_strap_sync (
    .clk(sys_clk), .rst(1'b0), .d(freq_strap), .q(strap_s)
  );

  // ----------------------------------------------------------------
  // configuration bytes (sys_clk)
  // ----------------------------------------------------------------
  localparam logic [79:0] RST_IMG = `CFG_RESET;
  localparam cfg_array_t CFG_INIT = {DEVICE_ID, RST_IMG[71:64], VENDOR_REV_ID, RST_IMG[55:0]};
  localparam cfg_array_t WMASK = `CFG_WMASK;

  logic req_wr_reg;
  logic [7:0] req_idx_reg;
  logic [7:0] req_data_reg;
  cfg_array_t cfg_reg, cfg_next;
  logic [7:0] rsp_data_reg, rsp_data_next;
  logic ack_tgl_next;
  logic seen_reg, seen_next;
  logic strap_taken_reg, strap_taken_next;
  logic req_new;

  assign req_new = (req_sync != seen_reg);

  always_comb
  begin
    cfg_next = cfg_reg;
    rsp_data_next = rsp_data_reg;
    ack_tgl_next = ack_tgl_reg;
    seen_next = req_sync;
    strap_taken_next = 1'b1;
    // strap caught once, first cycle after reset release
    if (!strap_taken_reg)
      cfg_next[`STRAP_BYTE][`STRAP_BIT] = strap_s;
    if (req_new)
    begin
      ack_tgl_next = req_sync;
      rsp_data_next = 8'h00;
      if (req_idx_reg <= `CFG_LAST_IDX)
      begin
        rsp_data_next = cfg_reg[req_idx_reg];
        if (req_wr_reg)
          cfg_next[req_idx_reg] = (cfg_reg[req_idx_reg] & ~WMASK[req_idx_reg]) |
                                  (req_data_reg & WMASK[req_idx_reg]);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cfg_reg <= CFG_INIT;
      rsp_data_reg <= 8'h00;
      ack_tgl_reg <= 1'b0;
      seen_reg <= 1'b0;
      strap_taken_reg <= 1'b0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      rsp_data_reg <= rsp_data_next;
      ack_tgl_reg <= ack_tgl_next;
      seen_reg <= seen_next;
      strap_taken_reg <= strap_taken_next;
    end
  end

  assign cfg_bytes = cfg_reg;

  // ----------------------------------------------------------------
  // bus engine (link_clk)
  // ----------------------------------------------------------------
  link_state_t state_reg, state_next;
  byte_kind_t kind_reg, kind_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_shift_reg, tx_shift_next;
  logic [7:0] addr_reg, addr_next;
  logic [7:0] index_reg, index_next;
  logic [7:0] remain_reg, remain_next;
  logic [7:0] tx_left_reg, tx_left_next;
  logic [7:0] rsp_link_reg, rsp_link_next;
  logic rd_mode_reg, rd_mode_next;
  logic ack_go_reg, ack_go_next;
  logic oe_reg, oe_next;
  logic req_tgl_next;
  logic req_wr_next;
  logic [7:0] req_idx_next;
  logic [7:0] req_data_next;
  logic scl_p_reg;
  logic sda_p_reg;
  logic ack_p_reg;
  logic sda_out_reg;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] rx_byte;

  assign scl_rise = scl_s & ~scl_p_reg;
  assign scl_fall = ~scl_s & scl_p_reg;
  assign bus_start = scl_s & scl_p_reg & sda_p_reg & ~sda_s;
  assign bus_stop = scl_s & scl_p_reg & ~sda_p_reg & sda_s;
  assign rx_byte = {shift_reg[6:0], sda_s};

  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_shift_next = tx_shift_reg;
    addr_next = addr_reg;
    index_next = index_reg;
    remain_next = remain_reg;
    tx_left_next = tx_left_reg;
    rd_mode_next = rd_mode_reg;
    ack_go_next = ack_go_reg;
    oe_next = oe_reg;
    req_tgl_next = req_tgl_reg;
    req_wr_next = req_wr_reg;
    req_idx_next = req_idx_reg;
    req_data_next = req_data_reg;
    rsp_link_next = (ack_sync != ack_p_reg) ? rsp_data_reg : rsp_link_reg;
    if (bus_start)
    begin
      // start or repeated start always re-arms address reception
      state_next = ST_RX;
      kind_next = K_ADDR;
      bit_cnt_next = 4'h0;
      oe_next = 1'b0;
    end
    else if (bus_stop)
    begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_RX:
          if (scl_rise)
          begin
            shift_next = rx_byte;
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == `BIT_LAST)
            begin
              state_next = ST_HOLD;
              ack_go_next = 1'b1;
              case (kind_reg)
                K_ADDR:
                begin
                  addr_next = rx_byte;
                  if (rx_byte == `SMB_WR_ADDR)
                    rd_mode_next = 1'b0;
                  else if (rx_byte == `SMB_RD_ADDR)
                  begin
                    rd_mode_next = 1'b1;
                    req_tgl_next = ~req_tgl_reg;
                    req_wr_next = 1'b0;
                    req_idx_next = `CNT_IDX;
                  end
                  else
                    ack_go_next = 1'b0;
                end
                K_INDEX: index_next = rx_byte;
                K_COUNT: remain_next = rx_byte;
                default:
                  if (remain_reg != 8'h00)
                  begin
                    req_tgl_next = ~req_tgl_reg;
                    req_wr_next = 1'b1;
                    req_idx_next = index_reg;
                    req_data_next = rx_byte;
                    index_next = index_reg + 8'h01;
                    remain_next = remain_reg - 8'h01;
                  end
                  else
                    ack_go_next = 1'b0;
              endcase
            end
          end
        ST_HOLD:
          if (scl_fall)
          begin
            state_next = ack_go_reg ? ST_ACK : ST_WAIT;
            oe_next = ack_go_reg;
          end
        ST_ACK:
          if (scl_fall)
          begin
            bit_cnt_next = 4'h0;
            if (kind_reg == K_ADDR && rd_mode_reg)
            begin
              // count byte goes out first
              state_next = ST_TX;
              tx_shift_next = rsp_link_reg;
              tx_left_next = rsp_link_reg;
              oe_next = ~rsp_link_reg[7];
            end
            else
            begin
              state_next = ST_RX;
              oe_next = 1'b0;
              kind_next = (kind_reg == K_ADDR) ? K_INDEX :
                          (kind_reg == K_INDEX) ? K_COUNT : K_DATA;
            end
          end
        ST_TX:
          if (scl_rise)
          begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == `BIT_LAST)
            begin
              // prefetch the byte for the next slot
              req_tgl_next = ~req_tgl_reg;
              req_wr_next = 1'b0;
              req_idx_next = index_reg;
              index_next = index_reg + 8'h01;
            end
          end
          else if (scl_fall)
          begin
            if (bit_cnt_reg == `BIT_DONE)
            begin
              state_next = ST_HACK;
              oe_next = 1'b0;
              ack_go_next = 1'b0;
            end
            else
            begin
              tx_shift_next = {tx_shift_reg[6:0], 1'b0};
              oe_next = ~tx_shift_reg[6];
            end
          end
        ST_HACK:
          if (scl_rise)
          begin
            if (sda_s)
              state_next = ST_WAIT;
            else
              ack_go_next = 1'b1;
          end
          else if (scl_fall && ack_go_reg)
          begin
            bit_cnt_next = 4'h0;
            if (tx_left_reg == 8'h00)
              state_next = ST_WAIT;
            else
            begin
              state_next = ST_TX;
              tx_shift_next = rsp_link_reg;
              tx_left_next = tx_left_reg - 8'h01;
              oe_next = ~rsp_link_reg[7];
            end
          end
        default:
          state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      state_reg <= ST_IDLE;
      kind_reg <= K_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      addr_reg <= 8'h00;
      index_reg <= 8'h00;
      remain_reg <= 8'h00;
      tx_left_reg <= 8'h00;
      rsp_link_reg <= 8'h00;
      rd_mode_reg <= 1'b0;
      ack_go_reg <= 1'b0;
      oe_reg <= 1'b0;
      req_tgl_reg <= 1'b0;
      req_wr_reg <= 1'b0;
      req_idx_reg <= 8'h00;
      req_data_reg <= 8'h00;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
      ack_p_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_shift_reg <= tx_shift_next;
      addr_reg <= addr_next;
      index_reg <= index_next;
      remain_reg <= remain_next;
      tx_left_reg <= tx_left_next;
      rsp_link_reg <= rsp_link_next;
      rd_mode_reg <= rd_mode_next;
      ack_go_reg <= ack_go_next;
      oe_reg <= oe_next;
      req_tgl_reg <= req_tgl_next;
      req_wr_reg <= req_wr_next;
      req_idx_reg <= req_idx_next;
      req_data_reg <= req_data_next;
      scl_p_reg <= scl_s;
      sda_p_reg <= sda_s;
      ack_p_reg <= ack_sync;
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_oe = oe_reg;
  assign sda_out = sda_out_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_wr_addr_ack:
  assert property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == ST_ACK && kind_reg == K_ADDR && !rd_mode_reg) |-> addr_reg == `SMB_WR_ADDR)
    else $error("write address acknowledged for wrong byte");
  chk_rd_addr_ack:
  assert property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == ST_ACK && kind_reg == K_ADDR && rd_mode_reg) |-> addr_reg == `SMB_RD_ADDR)
    else $error("read address acknowledged for wrong byte");
  chk_ack_drive:
  assert property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == ST_HOLD && ack_go_reg && scl_fall) |=> (state_reg == ST_ACK && sda_oe))
    else $error("acknowledge not driven after accepted byte");
  chk_count_ack:
  assert property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == ST_HOLD && kind_reg == K_COUNT && scl_fall && !bus_start && !bus_stop)
    |=> state_reg == ST_ACK)
    else $error("byte count not acknowledged");
  chk_data_store:
  assert property (@(posedge link_clk) disable iff (link_rst)
    ($changed(req_tgl_reg) && req_wr_reg) |-> (index_reg == req_idx_reg + 8'h01))
    else $error("write index not advancing");
  chk_data_ack:
  assert property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == ST_ACK) |-> sda_oe ##0 (kind_reg != K_DATA || !rd_mode_reg))
    else $error("data acknowledge lost");
  chk_tx_after_ack:
  assert property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == ST_TX && $past(state_reg) != ST_TX)
    |-> ($past(state_reg) == ST_ACK || $past(state_reg) == ST_HACK))
    else $error("data driven before acknowledge");
  chk_count_first:
  assert property (@(posedge link_clk) disable iff (link_rst)
    ($past(state_reg) == ST_ACK && state_reg == ST_TX) |-> (tx_left_reg == tx_shift_reg))
    else $error("first read byte is not the count");
  chk_count_reset:
  assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> cfg_reg[`CNT_IDX] == `COUNT_RESET)
    else $error("read-back count reset value wrong");
  chk_ro_keep:
  assert property (@(posedge sys_clk) disable iff (rst)
    ##1 ($stable(cfg_reg[7]) && $stable(cfg_reg[9])))
    else $error("read-only byte changed");
  chk_count_write:
  assert property (@(posedge sys_clk) disable iff (rst)
    (req_new && req_wr_reg && req_idx_reg == `CNT_IDX) |=> cfg_reg[`CNT_IDX] == $past(req_data_reg))
    else $error("read-back count not written");

  cov_data_ack: cover property (@(posedge link_clk) disable iff (link_rst)
    state_reg == ST_ACK && kind_reg == K_DATA);
  cov_read_count: cover property (@(posedge link_clk) disable iff (link_rst)
    $past(state_reg) == ST_ACK && state_reg == ST_TX);
  cov_host_nack: cover property (@(posedge link_clk) disable iff (link_rst)
    state_reg == ST_HACK && scl_rise && sda_s);

endmodule : smbus_index_block_access

`default_nettype wire
